// ==== hdl/bus_match_fifo_pkg.sv ====
package bus_match_fifo_pkg;
  localparam int DATA_W = 36;
  localparam int BYTE_W = 9;
  localparam int WORD_W = 18;
  localparam int DEPTH = 8;
  localparam int CNT_W = 4;
  localparam int ADDR_W = 3;
  localparam int REG_W = 32;
  localparam int PIN_W = 2 * DATA_W + 9;
  localparam logic [ADDR_W-1:0] A_AE_OFFSET_ADDR = 3'h0;
  localparam logic [ADDR_W-1:0] B_AE_OFFSET_ADDR = 3'h1;
  localparam logic [ADDR_W-1:0] A_AF_OFFSET_ADDR = 3'h2;
  localparam logic [ADDR_W-1:0] B_AF_OFFSET_ADDR = 3'h3;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 3'h4;
  localparam logic [CNT_W-1:0] OFFSET_RST = 4'h2;
  localparam logic [2:0] PARTS_LONG = 3'h1;
  localparam logic [2:0] PARTS_WORD = 3'h2;
  localparam logic [2:0] PARTS_BYTE = 3'h4;
endpackage : bus_match_fifo_pkg

// ==== hdl/fifo_store.sv ====
`timescale 1ns/1ns
module fifo_store #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8,
  parameter int AW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_rd_data = rd_en ? mem[rd_addr] : rd_data;
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end
endmodule : fifo_store

// ==== hdl/gray_fifo.sv ====
`timescale 1ns/1ns
module gray_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  input wire logic [$clog2(DEPTH):0] af_offset,
  input wire logic [$clog2(DEPTH):0] ae_offset,
  output logic wr_almost_full_n,
  output logic rd_almost_empty_n,
  output logic [$clog2(DEPTH):0] rd_count
);
  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [PW-1:0] DEPTH_P = PW'(DEPTH);

  function automatic logic [PW-1:0] gray_to_bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = g[i] ^ b[i + 1];
    end
    return b;
  endfunction : gray_to_bin

  logic [PW-1:0] wbin, wgray, rbin, rgray, ws1, ws2, rs1, rs2;
  logic [PW-1:0] next_wbin, next_rbin, ws_bin, rs_bin, wr_count;
  logic next_out_valid, next_af_n, next_ae_n, push, fetch;

  always_comb begin
    ws_bin = gray_to_bin(ws2);
    rs_bin = gray_to_bin(rs2);
    wr_count = wbin - rs_bin; // [R17]
    rd_count = ws_bin - rbin + PW'(out_valid); // [R17]
    in_ready = wr_count != DEPTH_P;
    push = in_valid && in_ready;
    fetch = (ws_bin != rbin) && (!out_valid || out_ready);
    next_wbin = push ? wbin + 1'b1 : wbin;
    next_rbin = fetch ? rbin + 1'b1 : rbin;
    next_out_valid = fetch || (out_valid && !out_ready);
    next_af_n = !((DEPTH_P - wr_count) <= af_offset); // [R4] [R5]
    next_ae_n = !(rd_count <= ae_offset); // [R2] [R3]
  end

  // Gray pointers cross through two stages so a count never sees a torn value
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wbin <= '0;
      wgray <= '0;
      rbin <= '0;
      rgray <= '0;
      ws1 <= '0;
      ws2 <= '0;
      rs1 <= '0;
      rs2 <= '0;
      out_valid <= 1'b0;
      wr_almost_full_n <= 1'b0;
      rd_almost_empty_n <= 1'b0;
    end else begin
      wbin <= next_wbin;
      wgray <= next_wbin ^ (next_wbin >> 1);
      rbin <= next_rbin;
      rgray <= next_rbin ^ (next_rbin >> 1);
      ws1 <= wgray; // [R16] [R17]
      ws2 <= ws1;
      rs1 <= rgray; // [R16] [R17]
      rs2 <= rs1;
      out_valid <= next_out_valid;
      wr_almost_full_n <= next_af_n;
      rd_almost_empty_n <= next_ae_n;
    end
  end

  fifo_store #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) store (
    .clk(clk),
    .rst_n(rst_n),
    .wr_en(push),
    .wr_addr(wbin[AW-1:0]),
    .wr_data(in_data),
    .rd_en(fetch),
    .rd_addr(rbin[AW-1:0]),
    .rd_data(out_data)
  );
endmodule : gray_fifo

// ==== hdl/bidir_match_fifo.sv ====
// What this block does
// R1: Each side has a 36-bit two-way data bus, driven on reads, sampled on writes.
// R2: A almost-empty low when B-to-A word count is at or below its offset.
// R3: B almost-empty low when A-to-B word count is at or below its offset.
// R4: A almost-full low when A-to-B free space is at or below its offset.
// R5: B almost-full low when B-to-A free space is at or below its offset.
// R6: Select high at reset latches big-endian: most significant part first on B.
// R7: Select low at reset latches little-endian: least significant part first on B.
// R8: After reset the select chooses timing: high standard, low fall-through.
// R9: The controller keeps the timing select static once chosen.
// R10: Bus-match high gives byte or word B width by size select; low long word.
// R11: The system keeps bus-match static during operation.
// R12: A clock runs continuously and may equal the B clock.
// R13: All A-side flags update only on the rising clock edge.
// R14: An A transfer needs the port enable high at the clock edge.
// R15: An A transfer needs chip select low; A bus released while it is high.
// R16: Full flags sync to writer clock, empty flags to reader clock, two stages.
// R17: Fill levels come from gray pointers crossed between domains, never torn.
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns
module bidir_match_fifo (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [35:0] side_a_data_bus_in,
  output logic [35:0] side_a_data_bus_out,
  output logic side_a_data_bus_oe,
  input wire logic side_a_chip_select_n,
  input wire logic side_a_port_enable,
  input wire logic side_a_write_select,
  input wire logic [35:0] side_b_data_bus_in,
  output logic [35:0] side_b_data_bus_out,
  output logic side_b_data_bus_oe,
  input wire logic side_b_chip_select_n,
  input wire logic side_b_port_enable,
  input wire logic side_b_write_select,
  input wire logic endian_timing_select,
  input wire logic b_bus_match_select,
  input wire logic b_size_select,
  output logic side_a_full_input_ready,
  output logic side_a_empty_output_ready,
  output logic side_a_almost_full_flag,
  output logic side_a_almost_empty_flag,
  output logic side_b_full_input_ready,
  output logic side_b_empty_output_ready,
  output logic side_b_almost_full_flag,
  output logic side_b_almost_empty_flag,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata
);
  localparam int DW = bus_match_fifo_pkg::DATA_W;
  localparam int CW = bus_match_fifo_pkg::CNT_W;

  function automatic logic [35:0] get_part(input logic [35:0] w, input logic [1:0] idx,
                                           input logic [2:0] n, input logic big);
    logic [1:0] sel;
    sel = big ? 2'(n - 3'h1) - idx : idx;
    case (n)
      bus_match_fifo_pkg::PARTS_BYTE: get_part = 36'(w[sel * 9 +: 9]);
      bus_match_fifo_pkg::PARTS_WORD: get_part = 36'(w[sel[0] * 18 +: 18]);
      default: get_part = w;
    endcase
  endfunction : get_part

  function automatic logic [35:0] put_part(input logic [35:0] w, input logic [35:0] d,
                                           input logic [1:0] idx, input logic [2:0] n, input logic big);
    logic [1:0] sel;
    sel = big ? 2'(n - 3'h1) - idx : idx;
    put_part = w;
    case (n)
      bus_match_fifo_pkg::PARTS_BYTE: put_part[sel * 9 +: 9] = d[8:0];
      bus_match_fifo_pkg::PARTS_WORD: put_part[sel[0] * 18 +: 18] = d[17:0];
      default: put_part = d;
    endcase
  endfunction : put_part

  // Every A, B and select pin passes two flops; data and strobes share the delay so stay aligned
  logic [bus_match_fifo_pkg::PIN_W-1:0] pin_raw, pin_s1, pin_s2;
  logic [35:0] a_din, b_din;
  logic a_cs_n, a_en, a_wr, b_cs_n, b_en, b_wr, ets, bm, bsize;

  assign pin_raw = {side_a_data_bus_in, side_a_chip_select_n, side_a_port_enable, side_a_write_select,
                    side_b_data_bus_in, side_b_chip_select_n, side_b_port_enable, side_b_write_select,
                    endian_timing_select, b_bus_match_select, b_size_select};
  assign {a_din, a_cs_n, a_en, a_wr, b_din, b_cs_n, b_en, b_wr, ets, bm, bsize} = pin_s2;

  // No reset here: the select pin must already be through the sync at the first edge after reset
  // Outputs are held in reset meanwhile, so pin values seen during reset do no harm
  always_ff @(posedge clk) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
  end

  // Endian order caught on the first edge after reset release; timing and width follow the live pins
  // Endian order is the synchronised select as it stood while reset was held
  logic configured, big_endian, fall_through_timing, next_configured, next_big_endian;
  logic [2:0] n_parts;

  always_comb begin
    next_configured = 1'b1;
    next_big_endian = configured ? big_endian : ets; // [R6] [R7]
    fall_through_timing = configured && !ets; // [R8]
    n_parts = !bm ? bus_match_fifo_pkg::PARTS_LONG :
              (bsize ? bus_match_fifo_pkg::PARTS_BYTE : bus_match_fifo_pkg::PARTS_WORD); // [R10]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      configured <= 1'b0;
      big_endian <= 1'b0;
    end else begin
      configured <= next_configured;
      big_endian <= next_big_endian;
    end
  end

  // Offset registers steer the almost flags; status shows live state
  logic [CW-1:0] a_almost_empty_offset, b_almost_empty_offset, a_almost_full_offset, b_almost_full_offset;
  logic [CW-1:0] next_a_ae, next_b_ae, next_a_af, next_b_af, ab_rd_count, ba_rd_count;
  logic [31:0] next_reg_rdata;

  always_comb begin
    next_a_ae = a_almost_empty_offset;
    next_b_ae = b_almost_empty_offset;
    next_a_af = a_almost_full_offset;
    next_b_af = b_almost_full_offset;
    if (reg_write) begin
      case (reg_addr)
        bus_match_fifo_pkg::A_AE_OFFSET_ADDR: next_a_ae = reg_wdata[CW-1:0];
        bus_match_fifo_pkg::B_AE_OFFSET_ADDR: next_b_ae = reg_wdata[CW-1:0];
        bus_match_fifo_pkg::A_AF_OFFSET_ADDR: next_a_af = reg_wdata[CW-1:0];
        bus_match_fifo_pkg::B_AF_OFFSET_ADDR: next_b_af = reg_wdata[CW-1:0];
        default: next_a_ae = a_almost_empty_offset;
      endcase
    end
    next_reg_rdata = 32'h0;
    if (reg_read) begin
      case (reg_addr)
        bus_match_fifo_pkg::A_AE_OFFSET_ADDR: next_reg_rdata = 32'(a_almost_empty_offset);
        bus_match_fifo_pkg::B_AE_OFFSET_ADDR: next_reg_rdata = 32'(b_almost_empty_offset);
        bus_match_fifo_pkg::A_AF_OFFSET_ADDR: next_reg_rdata = 32'(a_almost_full_offset);
        bus_match_fifo_pkg::B_AF_OFFSET_ADDR: next_reg_rdata = 32'(b_almost_full_offset);
        bus_match_fifo_pkg::STATUS_ADDR: next_reg_rdata = {20'h0, ba_rd_count, ab_rd_count, 2'h0, fall_through_timing, big_endian};
        default: next_reg_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_almost_empty_offset <= bus_match_fifo_pkg::OFFSET_RST;
      b_almost_empty_offset <= bus_match_fifo_pkg::OFFSET_RST;
      a_almost_full_offset <= bus_match_fifo_pkg::OFFSET_RST;
      b_almost_full_offset <= bus_match_fifo_pkg::OFFSET_RST;
      reg_rdata <= 32'h0;
    end else begin
      a_almost_empty_offset <= next_a_ae;
      b_almost_empty_offset <= next_b_ae;
      a_almost_full_offset <= next_a_af;
      b_almost_full_offset <= next_b_af;
      reg_rdata <= next_reg_rdata;
    end
  end

  // The two buffers
  logic ab_in_valid, ab_in_ready, ab_out_valid, ab_out_ready, ba_in_valid, ba_in_ready, ba_out_valid, ba_out_ready;
  logic [DW-1:0] ab_out_data, ba_in_data, ba_out_data;

  gray_fifo #(.WIDTH(DW), .DEPTH(bus_match_fifo_pkg::DEPTH)) a_to_b_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(ab_in_valid),
    .in_ready(ab_in_ready),
    .in_data(a_din),
    .out_valid(ab_out_valid),
    .out_ready(ab_out_ready),
    .out_data(ab_out_data),
    .af_offset(a_almost_full_offset),
    .ae_offset(b_almost_empty_offset),
    .wr_almost_full_n(side_a_almost_full_flag),
    .rd_almost_empty_n(side_b_almost_empty_flag),
    .rd_count(ab_rd_count)
  );

  gray_fifo #(.WIDTH(DW), .DEPTH(bus_match_fifo_pkg::DEPTH)) b_to_a_buffer (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(ba_in_valid),
    .in_ready(ba_in_ready),
    .in_data(ba_in_data),
    .out_valid(ba_out_valid),
    .out_ready(ba_out_ready),
    .out_data(ba_out_data),
    .af_offset(b_almost_full_offset),
    .ae_offset(a_almost_empty_offset),
    .wr_almost_full_n(side_b_almost_full_flag),
    .rd_almost_empty_n(side_a_almost_empty_flag),
    .rd_count(ba_rd_count)
  );

  // Side A: long-word port; flags are flops or fifo flops, all on the rising edge
  logic a_access, a_hold, next_a_hold, next_a_oe;
  logic [35:0] next_a_out;

  always_comb begin
    a_access = configured && a_en && !a_cs_n; // [R14] [R15] [R12]
    ab_in_valid = a_access && a_wr; // [R1]
    next_a_oe = !a_cs_n && !a_wr; // [R15]
    next_a_out = side_a_data_bus_out;
    next_a_hold = a_hold;
    if (fall_through_timing) begin
      ba_out_ready = ba_out_valid && (!a_hold || (a_access && !a_wr));
      if (ba_out_ready) begin
        next_a_hold = 1'b1;
      end else if (a_access && !a_wr) begin
        next_a_hold = 1'b0;
      end
    end else begin
      ba_out_ready = ba_out_valid && a_access && !a_wr;
      next_a_hold = 1'b0;
    end
    if (ba_out_ready) begin
      next_a_out = ba_out_data; // [R1]
    end
    side_a_full_input_ready = ab_in_ready; // [R13]
    side_a_empty_output_ready = fall_through_timing ? a_hold : ba_out_valid; // [R13] [R8]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      side_a_data_bus_out <= 36'h0;
      side_a_data_bus_oe <= 1'b0;
      a_hold <= 1'b0;
    end else begin
      side_a_data_bus_out <= next_a_out;
      side_a_data_bus_oe <= next_a_oe;
      a_hold <= next_a_hold;
    end
  end

  // Side B: parts of a long word split and assembled in the latched order
  logic b_access, b_rd, b_wr_go, b_hold, next_b_hold, next_b_oe, b_rlast, b_wlast;
  logic [1:0] b_rpart, b_wpart, next_b_rpart, next_b_wpart;
  logic [35:0] b_word, b_asm, next_b_out, next_b_word, next_b_asm;

  always_comb begin
    b_access = configured && b_en && !b_cs_n;
    b_rd = b_access && !b_wr;
    b_rlast = 3'(b_rpart) == n_parts - 3'h1;
    b_wlast = 3'(b_wpart) == n_parts - 3'h1;
    next_b_oe = !b_cs_n && !b_wr;
    next_b_out = side_b_data_bus_out;
    next_b_word = b_word;
    next_b_hold = b_hold;
    next_b_rpart = b_rpart;
    ab_out_ready = 1'b0;
    if (b_rd && b_hold && !(fall_through_timing && b_rlast)) begin
      next_b_out = get_part(b_word, fall_through_timing ? b_rpart + 2'h1 : b_rpart, n_parts, big_endian); // [R6] [R7]
      next_b_rpart = b_rlast ? 2'h0 : b_rpart + 2'h1;
      next_b_hold = !b_rlast;
    end else if ((b_rd || (fall_through_timing && !b_hold)) || (fall_through_timing && b_rd && b_rlast)) begin
      next_b_hold = 1'b0;
      next_b_rpart = 2'h0;
      if (ab_out_valid) begin
        ab_out_ready = 1'b1;
        next_b_word = ab_out_data;
        next_b_out = get_part(ab_out_data, 2'h0, n_parts, big_endian); // [R1] [R6] [R7]
        next_b_hold = fall_through_timing || (n_parts != bus_match_fifo_pkg::PARTS_LONG);
        next_b_rpart = (fall_through_timing || n_parts == bus_match_fifo_pkg::PARTS_LONG) ? 2'h0 : 2'h1;
      end
    end
    b_wr_go = b_access && b_wr && (!b_wlast || ba_in_ready);
    next_b_asm = b_wr_go ? put_part(b_asm, b_din, b_wpart, n_parts, big_endian) : b_asm; // [R6] [R7]
    next_b_wpart = b_wr_go ? (b_wlast ? 2'h0 : b_wpart + 2'h1) : b_wpart;
    ba_in_valid = b_wr_go && b_wlast; // [R1]
    ba_in_data = put_part(b_asm, b_din, b_wpart, n_parts, big_endian);
    side_b_full_input_ready = ba_in_ready;
    side_b_empty_output_ready = fall_through_timing ? b_hold : (b_hold || ab_out_valid);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      side_b_data_bus_out <= 36'h0;
      side_b_data_bus_oe <= 1'b0;
      b_hold <= 1'b0;
      b_rpart <= 2'h0;
      b_wpart <= 2'h0;
      b_word <= 36'h0;
      b_asm <= 36'h0;
    end else begin
      side_b_data_bus_out <= next_b_out;
      side_b_data_bus_oe <= next_b_oe;
      b_hold <= next_b_hold;
      b_rpart <= next_b_rpart;
      b_wpart <= next_b_wpart;
      b_word <= next_b_word;
      b_asm <= next_b_asm;
    end
  end
endmodule : bidir_match_fifo

// ==== bench/fifo_props.sv ====
`timescale 1ns/1ns
module fifo_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic side_a_chip_select_n,
  input wire logic side_a_write_select,
  input wire logic side_a_data_bus_oe,
  input wire logic side_b_chip_select_n,
  input wire logic side_b_data_bus_oe,
  input wire logic side_a_full_input_ready,
  input wire logic side_a_almost_full_flag,
  input wire logic side_a_empty_output_ready,
  input wire logic side_a_almost_empty_flag,
  input wire logic side_b_empty_output_ready,
  input wire logic side_b_almost_empty_flag,
  input wire logic [2:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [31:0] reg_rdata
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  a_bus_drive_a: assert property (side_a_data_bus_oe |-> $past(!side_a_chip_select_n && !side_a_write_select, 3))
    else $error("A bus driven without a selected read");
  b_bus_release_a: assert property (side_b_chip_select_n [*4] |-> !side_b_data_bus_oe)
    else $error("B bus driven while deselected");
  // Flags lag the counts through the synchronisers, hence the short window
  a_full_af_a: assert property ($fell(side_a_full_input_ready) |-> ##[0:6] !side_a_almost_full_flag)
    else $error("A almost full missing at full");
  b_empty_ae_a: assert property ($fell(side_b_empty_output_ready) |-> ##[0:6] !side_b_almost_empty_flag)
    else $error("B almost empty missing at empty");
  a_empty_ae_a: assert property ($fell(side_a_empty_output_ready) |-> ##[0:6] !side_a_almost_empty_flag)
    else $error("A almost empty missing at empty");
  b_idle_ae_a: assert property (!side_b_empty_output_ready [*8] |-> !side_b_almost_empty_flag)
    else $error("B almost empty high while empty");
  a_full_hold_a: assert property (!side_a_full_input_ready [*8] |-> !side_a_almost_full_flag)
    else $error("A almost full high while full");
  offset_readback_a: assert property (reg_write && reg_addr == 3'h2 ##1 reg_read && reg_addr == 3'h2
    |=> reg_rdata[3:0] == $past(reg_wdata[3:0], 2))
    else $error("offset readback differs from write");
  unmapped_zero_a: assert property (reg_read && reg_addr > 3'h4 |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
endmodule : fifo_props

// ==== bench/port_peer.sv ====
`timescale 1ns/1ns
module port_peer (
  input wire logic clk,
  input wire logic [35:0] bus,
  output logic cs_n,
  output logic en,
  output logic ws,
  output logic [35:0] drive
);
  initial begin
    cs_n = 1'b1;
    en = 1'b0;
    ws = 1'b0;
    drive = 36'h0;
  end
  task automatic put(input logic [35:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    en <= 1'b1;
    ws <= 1'b1;
    drive <= d;
    @(posedge clk);
    cs_n <= 1'b1;
    en <= 1'b0;
    ws <= 1'b0;
    drive <= ~d; // Released lines show the inverse so stale data cannot pass
  endtask : put
  // Select stays low after the pulse so the answer is on the bus when it lands
  task automatic get(output logic [35:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    en <= 1'b1;
    ws <= 1'b0;
    @(posedge clk);
    en <= 1'b0;
    repeat (5) @(posedge clk);
    d = bus;
    cs_n <= 1'b1;
    repeat (4) @(posedge clk); // Let the device release the bus before the next write
  endtask : get
endmodule : port_peer

// ==== bench/tb_bidirectional_bus_matching_fifo.sv ====
`timescale 1ns/1ns
module tb_bidirectional_bus_matching_fifo;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic ets = 1'b1;
  logic bm = 1'b0;
  logic bsize = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic [35:0] a_out, a_drv, a_bus, b_out, b_drv, b_bus;
  logic a_oe, a_cs_n, a_en, a_ws, b_oe, b_cs_n, b_en, b_ws;
  logic a_full, a_empty, a_af, a_ae, b_full, b_empty, b_af, b_ae;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  assign a_bus = a_oe ? a_out : a_drv;
  assign b_bus = b_oe ? b_out : b_drv;
  initial begin
    forever #4 clk = ~clk;
  end
  // One clock for both ports: the coincident case
  bidir_match_fifo u_dut (
    .clk(clk), .rst_n(rst_n),
    .side_a_data_bus_in(a_bus), .side_a_data_bus_out(a_out), .side_a_data_bus_oe(a_oe),
    .side_a_chip_select_n(a_cs_n), .side_a_port_enable(a_en), .side_a_write_select(a_ws),
    .side_b_data_bus_in(b_bus), .side_b_data_bus_out(b_out), .side_b_data_bus_oe(b_oe),
    .side_b_chip_select_n(b_cs_n), .side_b_port_enable(b_en), .side_b_write_select(b_ws),
    .endian_timing_select(ets), .b_bus_match_select(bm), .b_size_select(bsize),
    .side_a_full_input_ready(a_full), .side_a_empty_output_ready(a_empty),
    .side_a_almost_full_flag(a_af), .side_a_almost_empty_flag(a_ae),
    .side_b_full_input_ready(b_full), .side_b_empty_output_ready(b_empty),
    .side_b_almost_full_flag(b_af), .side_b_almost_empty_flag(b_ae),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
  );
  port_peer u_pa (.clk(clk), .bus(a_bus), .cs_n(a_cs_n), .en(a_en), .ws(a_ws), .drive(a_drv));
  port_peer u_pb (.clk(clk), .bus(b_bus), .cs_n(b_cs_n), .en(b_en), .ws(b_ws), .drive(b_drv));
  task automatic chk(input string what, input logic [35:0] exp, input logic [35:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  function automatic logic [35:0] part(input logic [35:0] w, input int k, input int n, input logic big);
    int sz;
    int idx;
    sz = 36 / n;
    idx = big ? n - 1 - k : k;
    return (w >> (idx * sz)) & ((36'h1 << sz) - 36'h1);
  endfunction : part
  task automatic do_reset(input logic big, input logic narrow, input logic bytesz, input logic fall_through_timing);
    rst_n <= 1'b0;
    ets <= big;
    bm <= narrow;
    bsize <= bytesz;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    ets <= ~fall_through_timing;
    repeat (4) @(posedge clk);
  endtask : do_reset
  // Register tasks start right after an edge so strobes can run back to back
  task automatic reg_wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [2:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask : reg_rd
  task automatic t_regs();
    logic [31:0] d;
    for (int i = 0; i < 4; i++) begin
      reg_rd(3'(i), d);
      chk("offset reset", 36'(bus_match_fifo_pkg::OFFSET_RST), 36'(d));
    end
    reg_rd(bus_match_fifo_pkg::STATUS_ADDR, d);
    chk("status mode", 36'h1, 36'(d[1:0]));
    reg_rd(3'h7, d);
    chk("unmapped read", 36'h0, 36'(d));
    reg_wr(bus_match_fifo_pkg::A_AF_OFFSET_ADDR, 32'h5);
    reg_rd(bus_match_fifo_pkg::A_AF_OFFSET_ADDR, d);
    chk("offset write", 36'h5, 36'(d));
    $display("test regs done");
  endtask : t_regs
  task automatic t_long();
    logic [35:0] d;
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    chk("a almost full idle", 36'h1, 36'(a_af));
    for (int i = 0; i < 10; i++) begin
      u_pa.put(36'hA_5000_0000 + 36'(i));
    end
    repeat (8) @(posedge clk);
    chk("a full", 36'h0, 36'(a_full));
    chk("a almost full", 36'h0, 36'(a_af));
    chk("b almost empty filled", 36'h1, 36'(b_ae));
    for (int i = 0; i < 9; i++) begin
      u_pb.get(d);
      chk("b long word", 36'hA_5000_0000 + 36'(i), d);
    end
    repeat (8) @(posedge clk);
    chk("b empty", 36'h0, 36'(b_empty));
    chk("b almost empty drained", 36'h0, 36'(b_ae));
    chk("a almost full drained", 36'h1, 36'(a_af));
    $display("test long done");
  endtask : t_long
  task automatic t_narrow(input logic big, input logic bytesz);
    logic [35:0] d;
    int n;
    n = bytesz ? 4 : 2;
    do_reset(big, 1'b1, bytesz, 1'b0);
    for (int k = 0; k < n; k++) begin
      u_pb.put(part(36'h9_A5C3_6E1B, k, n, big));
    end
    repeat (6) @(posedge clk);
    u_pa.get(d);
    chk("a assembled", 36'h9_A5C3_6E1B, d);
    u_pa.put(36'h3_1D7E_84C2);
    repeat (6) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      u_pb.get(d);
      chk("b part", part(36'h3_1D7E_84C2, k, n, big), d);
    end
    $display("test narrow done");
  endtask : t_narrow
  task automatic t_fall_through_timing();
    logic [31:0] d;
    do_reset(1'b0, 1'b0, 1'b0, 1'b1);
    reg_rd(bus_match_fifo_pkg::STATUS_ADDR, d);
    chk("status fall_through_timing", 36'h2, 36'(d[1:0]));
    u_pb.put(36'h5_0F0F_A3C1);
    repeat (10) @(posedge clk);
    chk("a ready fall_through_timing", 36'h1, 36'(a_empty));
    chk("a fall through", 36'h5_0F0F_A3C1, a_out);
    chk("a almost empty fall_through_timing", 36'h0, 36'(a_ae));
    chk("b almost full idle", 36'h1, 36'(b_af));
    for (int i = 0; i < 9; i++) begin
      u_pb.put(36'h6_0000_0000 + 36'(i));
    end
    repeat (8) @(posedge clk);
    chk("b full", 36'h0, 36'(b_full));
    chk("b almost full", 36'h0, 36'(b_af));
    chk("a almost empty filled", 36'h1, 36'(a_ae));
    $display("test fall_through_timing done");
  endtask : t_fall_through_timing
  initial begin
    do_reset(1'b1, 1'b0, 1'b0, 1'b0);
    t_regs();
    t_long();
    t_narrow(1'b1, 1'b1);
    t_narrow(1'b0, 1'b0);
    t_fall_through_timing();
    end_sim();
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      failures++;
      end_sim();
    end
  end
endmodule : tb_bidirectional_bus_matching_fifo
bind bidir_match_fifo fifo_props u_props (
  .clk(clk), .rst_n(rst_n),
  .side_a_chip_select_n(side_a_chip_select_n), .side_a_write_select(side_a_write_select),
  .side_a_data_bus_oe(side_a_data_bus_oe), .side_b_chip_select_n(side_b_chip_select_n),
  .side_b_data_bus_oe(side_b_data_bus_oe), .side_a_full_input_ready(side_a_full_input_ready),
  .side_a_almost_full_flag(side_a_almost_full_flag), .side_a_empty_output_ready(side_a_empty_output_ready),
  .side_a_almost_empty_flag(side_a_almost_empty_flag), .side_b_empty_output_ready(side_b_empty_output_ready),
  .side_b_almost_empty_flag(side_b_almost_empty_flag), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
);
